// [logic/lpm_counter.sv]
// Down counter used for stop-recovery reset hold
`timescale 1ns/100ps
`default_nettype none
module lpm_counter #(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Control
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] load_val_in,
   input  wire logic             tick_in,
   // Status
   output logic                  done_out
);
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] cnt_nxt;
   // Count ticks down to zero; load takes priority
   always_comb begin
      cnt_nxt = cnt_r;
      if (load_in) begin
         cnt_nxt = load_val_in;
      end else if (tick_in && cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      done_out = (cnt_r == '0) && !load_in;
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// [logic/lpm_ctrl.sv]
// Low-power mode controller: stop, halt and peripheral power control
// How it works
// RULE1 - Stop instruction enters stop mode
// RULE2 - Stop halts both oscillators, crystal pins low
// RULE3 - Stop halts clock, processor and counter
// RULE4 - Watchdog runs in stop only if enabled
// RULE5 - Brownout runs in stop per option bit
// RULE6 - Comparators run in stop unless disabled
// RULE7 - Other peripherals idle in stop
// RULE8 - Stop exits only through recovery sequence
// RULE9 - Software avoids stop on external clock
// RULE10 - Halt instruction enters halt mode
// RULE11 - Halt keeps oscillator and clock, stops processor
// RULE12 - Halt keeps watchdog oscillator, watchdog if enabled
// RULE13 - Other peripherals run during halt
// RULE14 - Halt exits on interrupt, watchdog or resets
// RULE15 - Halt wake under five microseconds
// RULE16 - Power bits gate their peripheral blocks
// RULE17 - Bit four disables brownout, ANDed with option
// RULE18 - Software writes zero to reserved bits
// RULE19 - Unused digital peripherals gated automatically
// RULE20 - Recovery holds reset for 66 oscillator cycles
// RULE21 - Enabled pin level change starts recovery
// RULE22 - Entry only after instruction completes
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl
   import lpm_pkg::*;
#(
   parameter int GPIO_W = 17
) (
   // Clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              sys_rst_in,
   // Processor instruction interface
   input  wire logic              stop_instr_in,
   input  wire logic              halt_instr_in,
   input  wire logic              instr_done_in,
   // Wake sources
   input  wire lpm_wake_s         wake_in,
   input  wire logic              wdt_exc_mode_in,
   input  wire logic [GPIO_W-1:0] gpio_in,
   input  wire logic [GPIO_W-1:0] gpio_smr_en_in,
   input  wire logic              ipo_tick_in,
   // Options and usage
   input  wire logic              bod_always_on_opt_in,
   input  wire logic              periph_busy_in,
   // Register port
   input  wire logic [11:0]       reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic [7:0]             reg_rdata_out,
   // Power outputs
   output var lpm_enables_s       enables_out,
   output logic                   xtal_pins_low_out,
   output logic                   smr_reset_out,
   output logic                   wdt_exception_out,
   output logic [1:0]             mode_out
);
   // ==========================================
   // State
   lpm_state_e state_r;
   lpm_state_e state_nxt;
   logic [7:0] pwrctl_r;
   logic [7:0] pwrctl_nxt;
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       pend_exc_r;
   logic       pend_exc_nxt;
   logic [1:0] cause_r;
   logic [1:0] cause_nxt;
   logic       pin_change;
   logic       hold_done;
   logic       load_hold;
   logic       halt_wake;
   logic       stop_wake;
   logic       wdt_stop_en;
   logic       wdt_en;

   assign wdt_stop_en = config_r[LPM_CFG_WDT_STOP];
   assign wdt_en      = config_r[LPM_CFG_WDT_EN];

   // ==========================================
   // Wake detection
   lpm_edge_detect #(
      .WIDTH      (GPIO_W)
   ) u_edge (
      .clk_in     (sys_clk_in),
      .rst_in     (sys_rst_in),
      .pin_in     (gpio_in),
      .enable_in  (gpio_smr_en_in),
      .arm_in     (state_r == LPM_STOP),
      .change_out (pin_change)
   );

   // Recovery hold counts internal oscillator ticks
   lpm_counter #(
      .WIDTH       (7)
   ) u_hold (
      .clk_in      (sys_clk_in),
      .rst_in      (sys_rst_in),
      .load_in     (load_hold),
      .load_val_in (7'(LPM_SMR_HOLD_CYC)),
      .tick_in     (ipo_tick_in),
      .done_out    (hold_done)
   );

   // Any listed event ends halt; wake is one cycle, far under the limit
   assign halt_wake = wake_in.irq | (wake_in.wdt_timeout & wdt_en)  // RULE14 RULE15
                    | wake_in.por | wake_in.bod_reset | wake_in.ext_reset;
   // In stop only the watchdog, if kept running, or pins can wake
   assign stop_wake = pin_change | (wake_in.wdt_timeout & wdt_en & wdt_stop_en); // RULE21 RULE8

   // ==========================================
   // Mode state machine
   always_comb begin
      state_nxt    = state_r;
      load_hold    = 1'b0;
      pend_exc_nxt = pend_exc_r;
      unique case (state_r)
         LPM_RUN: begin
            if (instr_done_in && stop_instr_in) begin  // RULE1 RULE22
               state_nxt = LPM_STOP;
            end else if (instr_done_in && halt_instr_in) begin  // RULE10 RULE22
               state_nxt = LPM_HALT;
            end
         end
         LPM_HALT: begin
            if (halt_wake) begin  // RULE14
               state_nxt = LPM_RUN;
            end
         end
         LPM_STOP: begin
            if (stop_wake) begin  // RULE8
               state_nxt    = LPM_RECOVER;
               load_hold    = 1'b1;
               pend_exc_nxt = wake_in.wdt_timeout & wdt_exc_mode_in & !pin_change;
            end
         end
         LPM_RECOVER: begin
            if (hold_done) begin  // RULE20
               state_nxt    = LPM_RUN;
               pend_exc_nxt = 1'b0;
            end
         end
      endcase
   end

   // ==========================================
   // Register file: write path and read data
   always_comb begin
      pwrctl_nxt = pwrctl_r;
      config_nxt = config_r;
      rdata_nxt  = 8'h00;
      cause_nxt  = cause_r;
      if (reg_wr_in && reg_addr_in == LPM_PWRCTL_ADDR) begin
         // Reserved bits are not stored; software must write them zero
         pwrctl_nxt = reg_wdata_in & LPM_PWRCTL_MASK;  // RULE18
      end
      if (reg_wr_in && reg_addr_in == LPM_CONFIG_ADDR) begin
         config_nxt = reg_wdata_in & LPM_CONFIG_MASK;
      end
      if (state_r == LPM_RECOVER && hold_done) begin
         cause_nxt = {1'b1, pend_exc_r};
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            LPM_PWRCTL_ADDR: rdata_nxt = pwrctl_r;
            LPM_CONFIG_ADDR: rdata_nxt = config_r;
            LPM_STATUS_ADDR: rdata_nxt = {4'h0, cause_r, state_r};
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_r    <= LPM_RUN;
         pwrctl_r   <= LPM_PWRCTL_RESET;
         config_r   <= LPM_CONFIG_RESET;
         rdata_r    <= 8'h00;
         pend_exc_r <= 1'b0;
         cause_r    <= 2'b00;
      end else begin
         state_r    <= state_nxt;
         pwrctl_r   <= pwrctl_nxt;
         config_r   <= config_nxt;
         rdata_r    <= rdata_nxt;
         pend_exc_r <= pend_exc_nxt;
         cause_r    <= cause_nxt;
      end
   end

   // ==========================================
   // Power domain enables, decoded from state so they follow it exactly
   always_comb begin
      logic in_stop;
      logic in_rec;
      logic bod_ok;
      in_stop = (state_r == LPM_STOP);
      in_rec  = (state_r == LPM_RECOVER);
      // Brownout in stop needs both the register and the option bit
      bod_ok  = !pwrctl_r[LPM_BOD_DIS_BIT] && bod_always_on_opt_in;  // RULE17 RULE16
      enables_out.xtal_en    = !in_stop;                   // RULE2 RULE11
      enables_out.ipo_en     = !in_stop;                   // RULE2
      enables_out.sysclk_en  = !in_stop;                   // RULE3 RULE11
      enables_out.cpu_run    = (state_r == LPM_RUN);        // RULE3 RULE11
      enables_out.wdt_osc_en = in_stop ? wdt_stop_en : 1'b1;  // RULE4 RULE12
      enables_out.wdt_run    = wdt_en && (!in_stop || wdt_stop_en);  // RULE4 RULE12
      enables_out.bod_en     = in_stop ? bod_ok : !pwrctl_r[LPM_BOD_DIS_BIT]; // RULE5 RULE17
      enables_out.cmp_en     = !config_r[LPM_CFG_CMP_DIS];  // RULE6
      // Digital peripherals clock only in run or halt and when in use
      enables_out.periph_en  = !in_stop && !in_rec && periph_busy_in;  // RULE7 RULE13 RULE19
      xtal_pins_low_out      = in_stop;                    // RULE2
      smr_reset_out          = in_rec;                     // RULE20
   end

   // Exception flagged in the last recovery cycle when a watchdog timeout alone woke stop in exception mode
   assign wdt_exception_out = (state_r == LPM_RECOVER) && hold_done && pend_exc_r;
   assign reg_rdata_out     = rdata_r;
   assign mode_out          = state_r;
endmodule
`default_nettype wire

// [logic/lpm_edge_detect.sv]
// Level change detector for stop-recovery pins
`timescale 1ns/100ps
`default_nettype none
module lpm_edge_detect #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Pins
   input  wire logic [WIDTH-1:0] pin_in,
   input  wire logic [WIDTH-1:0] enable_in,
   input  wire logic             arm_in,
   // Result
   output logic                  change_out
);
   logic [WIDTH-1:0] last_r;
   logic [WIDTH-1:0] last_nxt;
   // Keep tracking while disarmed so an old level never looks like a change
   always_comb begin
      last_nxt   = pin_in;
      change_out = arm_in && (|((pin_in ^ last_r) & enable_in));
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         last_r <= '0;
      end else begin
         last_r <= last_nxt;
      end
   end
endmodule
`default_nettype wire

// [logic/lpm_pkg.sv]
// Package of constants and types for the low-power mode controller
package lpm_pkg;
   // ==========================================
   // Register map
   localparam logic [11:0] LPM_PWRCTL_ADDR    = 12'hf80;
   localparam logic [7:0]  LPM_PWRCTL_RESET   = 8'h00;
   localparam int          LPM_BOD_DIS_BIT    = 4;
   localparam logic [7:0]  LPM_PWRCTL_MASK    = 8'h10;
   localparam logic [11:0] LPM_STATUS_ADDR    = 12'hf81;
   localparam logic [11:0] LPM_CONFIG_ADDR    = 12'hf82;
   localparam logic [7:0]  LPM_CONFIG_RESET   = 8'h00;
   localparam int          LPM_CFG_WDT_STOP   = 0;
   localparam int          LPM_CFG_WDT_EN     = 1;
   localparam int          LPM_CFG_CMP_DIS    = 2;
   localparam logic [7:0]  LPM_CONFIG_MASK    = 8'h07;
   // ==========================================
   // Timing
   localparam int          LPM_SMR_HOLD_CYC   = 66;
   localparam int          LPM_CLK_MHZ        = 250;
   localparam int          LPM_HALT_WAKE_NS   = 5000;
   localparam int          LPM_HALT_WAKE_CYC  = LPM_HALT_WAKE_NS * LPM_CLK_MHZ / 1000;
   // ==========================================
   // Power mode states, Gray along run -> halt -> stop -> recover -> run
   typedef enum logic [1:0] {
      LPM_RUN     = 2'b00,
      LPM_HALT    = 2'b01,
      LPM_STOP    = 2'b11,
      LPM_RECOVER = 2'b10
   } lpm_state_e;
   // Wake sources grouped
   typedef struct packed {
      logic irq;
      logic wdt_timeout;
      logic por;
      logic bod_reset;
      logic ext_reset;
   } lpm_wake_s;
   // Domain enables driven out
   typedef struct packed {
      logic xtal_en;
      logic ipo_en;
      logic sysclk_en;
      logic cpu_run;
      logic wdt_osc_en;
      logic wdt_run;
      logic bod_en;
      logic cmp_en;
      logic periph_en;
   } lpm_enables_s;
endpackage

// [tb/lpm_ctrl_monitor.sv]
// Port checker for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_monitor
   import lpm_pkg::*;
#(
   parameter int GPIO_W = 17
) (
   // Clock and reset
   input wire logic              sys_clk_in,
   input wire logic              sys_rst_in,
   // Watched inputs
   input wire logic              stop_instr_in,
   input wire logic              halt_instr_in,
   input wire logic              instr_done_in,
   input wire lpm_wake_s         wake_in,
   input wire logic [GPIO_W-1:0] gpio_in,
   input wire logic [GPIO_W-1:0] gpio_smr_en_in,
   input wire logic              ipo_tick_in,
   input wire logic              periph_busy_in,
   // Watched outputs
   input wire lpm_enables_s      enables_out,
   input wire logic              xtal_pins_low_out,
   input wire logic              smr_reset_out,
   input wire logic [1:0]        mode_out
);
   // ==========
   // Ticks seen in recovery; one short of the hold is the safe bound
   logic [7:0] tick_cnt_r;
   logic [7:0] tick_cnt_nxt;
   always_comb begin
      tick_cnt_nxt = 8'h00;
      if (mode_out == LPM_RECOVER) begin
         tick_cnt_nxt = tick_cnt_r + {7'h00, ipo_tick_in};
      end
   end
   always_ff @(posedge sys_clk_in) begin
      tick_cnt_r <= sys_rst_in ? 8'h00 : tick_cnt_nxt;
   end
   // ==========
   // Mode transitions and domain enables
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_stop_entry: assert property (
      instr_done_in && stop_instr_in && mode_out == LPM_RUN |=> mode_out == LPM_STOP)
      else $error("stop entry missed");
   a_halt_entry: assert property (
      instr_done_in && halt_instr_in && !stop_instr_in && mode_out == LPM_RUN
      |=> mode_out == LPM_HALT) else $error("halt entry missed");
   a_stop_osc: assert property (
      mode_out == LPM_STOP |-> !enables_out.xtal_en && !enables_out.ipo_en && xtal_pins_low_out)
      else $error("oscillators live in stop");
   a_stop_core: assert property (
      mode_out == LPM_STOP |-> !enables_out.sysclk_en && !enables_out.cpu_run
      && !enables_out.periph_en) else $error("core live in stop");
   a_halt_clock: assert property (
      mode_out == LPM_HALT |-> enables_out.xtal_en && enables_out.sysclk_en && !enables_out.cpu_run
      && enables_out.wdt_osc_en && enables_out.periph_en == periph_busy_in)
      else $error("halt enables wrong");
   a_stop_exit: assert property (
      mode_out == LPM_STOP |=> mode_out inside {LPM_STOP, LPM_RECOVER})
      else $error("stop left without recovery");
   a_halt_wake: assert property (
      mode_out == LPM_HALT && (wake_in.irq || wake_in.por || wake_in.bod_reset
      || wake_in.ext_reset) |=> mode_out == LPM_RUN) else $error("halt wake late");
   a_pin_wake: assert property (
      mode_out == LPM_STOP && |((gpio_in ^ $past(gpio_in)) & gpio_smr_en_in)
      |-> ##[1:3] mode_out == LPM_RECOVER) else $error("pin change ignored");
   a_hold_len: assert property (
      mode_out == LPM_RECOVER && tick_cnt_r < 8'd65 |=> mode_out == LPM_RECOVER && smr_reset_out)
      else $error("recovery hold short");
   // Main scenarios reached
   cover property (mode_out == LPM_HALT ##1 mode_out == LPM_RUN);
   cover property (mode_out == LPM_RECOVER ##1 mode_out == LPM_RUN);
   cover property (mode_out == LPM_STOP && enables_out.bod_en);
endmodule
bind lpm_ctrl lpm_ctrl_monitor #(.GPIO_W(GPIO_W)) u_lpm_ctrl_monitor (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .stop_instr_in(stop_instr_in),
   .halt_instr_in(halt_instr_in), .instr_done_in(instr_done_in), .wake_in(wake_in),
   .gpio_in(gpio_in), .gpio_smr_en_in(gpio_smr_en_in), .ipo_tick_in(ipo_tick_in),
   .periph_busy_in(periph_busy_in), .enables_out(enables_out),
   .xtal_pins_low_out(xtal_pins_low_out), .smr_reset_out(smr_reset_out), .mode_out(mode_out));
`default_nettype wire

// [tb/lpm_ctrl_tb.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module lpm_ctrl_tb
   import lpm_pkg::*;
;
   // ==========
   // Stimulus and observed signals
   logic         clk, rst, stop, halt, done, wexc_mode, tick, opt, busy, wr, rd;
   logic         xlow, smr, wexc;
   logic [1:0]   mode;
   logic [7:0]   wdata, rdata;
   logic [11:0]  addr;
   logic [16:0]  gpio, gen;
   lpm_wake_s    wake;
   lpm_enables_s en;
   int           bad_count, check_count;
   // Device with its default pin count
   lpm_ctrl u_lpm_ctrl (
      .sys_clk_in(clk), .sys_rst_in(rst), .stop_instr_in(stop), .halt_instr_in(halt),
      .instr_done_in(done), .wake_in(wake), .wdt_exc_mode_in(wexc_mode), .gpio_in(gpio),
      .gpio_smr_en_in(gen), .ipo_tick_in(tick), .bod_always_on_opt_in(opt),
      .periph_busy_in(busy), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .enables_out(en), .xtal_pins_low_out(xlow),
      .smr_reset_out(smr), .wdt_exception_out(wexc), .mode_out(mode));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========
   // Bus cycles and waits
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic instr(input logic s, input logic h);
      @(posedge clk);
      stop <= s;
      halt <= h;
      done <= 1'b1;
      @(posedge clk);
      {stop, halt, done} <= 3'b000;
      #1;
   endtask
   // Bounded so a stuck mode ends the run instead of hanging it
   task automatic wait_mode(input logic [1:0] m, input int n);
      for (int i = 0; i < n && mode !== m; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(mode, m)
      if (mode !== m) close_out;
   endtask
   // ==========
   // Scenarios
   task automatic t_regs;
      rd_chk(LPM_PWRCTL_ADDR, 8'h00);
      rd_chk(LPM_CONFIG_ADDR, 8'h00);
      wr_reg(LPM_PWRCTL_ADDR, 8'h10);
      rd_chk(LPM_PWRCTL_ADDR, 8'h10);
      `CHK(en.bod_en, 1'b0)
      wr_reg(LPM_STATUS_ADDR, 8'hff);
      rd_chk(LPM_STATUS_ADDR, 8'h00);
      rd_chk(12'habc, 8'h00);
      wr_reg(LPM_PWRCTL_ADDR, 8'h00);
      #1 `CHK(en.bod_en, 1'b1)
   endtask
   // Halt with one wake source, busy flag varied per source
   task automatic t_halt(input int k);
      busy <= k[0];
      instr(1'b0, 1'b1);
      `CHK(mode, LPM_HALT)
      `CHK({en.xtal_en, en.sysclk_en, en.cpu_run, en.wdt_osc_en, en.wdt_run}, 5'b11011)
      `CHK(en.periph_en, busy)
      repeat (3) @(posedge clk);
      #1 `CHK(mode, LPM_HALT)
      wake <= lpm_wake_s'(5'b10000 >> k);
      @(posedge clk);
      wake <= '0;
      #1 `CHK(mode, LPM_RUN)
   endtask
   // Stop, ignore non-sources, wake on pin p, then count the hold
   task automatic t_stop(input logic [7:0] c, input logic o, input int p);
      wr_reg(LPM_CONFIG_ADDR, c);
      opt <= o;
      gen <= 17'h00001 << p;
      instr(1'b1, 1'b1);
      `CHK(mode, LPM_STOP)
      `CHK({en.xtal_en, en.ipo_en, xlow, en.sysclk_en, en.cpu_run, en.periph_en}, 6'h08)
      `CHK({en.wdt_osc_en, en.wdt_run}, {2{c[0]}})
      `CHK({en.bod_en, en.cmp_en}, {o, ~c[2]})
      wake.irq <= 1'b1;
      gpio[0] <= ~gpio[0];
      repeat (3) @(posedge clk);
      wake.irq <= 1'b0;
      #1 `CHK(mode, LPM_STOP)
      gpio[p] <= ~gpio[p];
      wait_mode(LPM_RECOVER, 8);
      for (int i = 0; i < 66; i++) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         #1 if (i == 64) `CHK({mode, smr}, {LPM_RECOVER, 1'b1})
      end
      wait_mode(LPM_RUN, 6);
      `CHK(smr, 1'b0)
   endtask
   // Stop woken by a watchdog timeout in exception mode
   task automatic t_wdt;
      instr(1'b1, 1'b0);
      `CHK(mode, LPM_STOP)
      wake.wdt_timeout <= 1'b1;
      @(posedge clk);
      wake.wdt_timeout <= 1'b0;
      #1 `CHK(mode, LPM_RECOVER)
      repeat (66) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      #1 `CHK({mode, wexc}, {LPM_RECOVER, 1'b1})
      wait_mode(LPM_RUN, 2);
      `CHK(wexc, 1'b0)
      rd_chk(LPM_STATUS_ADDR, 8'h0c);
   endtask
   // ==========
   // Verdict and main sequence
   task automatic close_out;
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      {stop, halt, done, tick, opt, busy, wr, rd} = '0;
      wexc_mode = 1'b1;
      wake = '0;
      gpio = '0;
      gen = '0;
      addr = '0;
      wdata = '0;
      bad_count = 0;
      check_count = 0;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 `CHK({mode, en}, {LPM_RUN, 9'h1f6})
      t_regs;
      wr_reg(LPM_CONFIG_ADDR, 8'h02);
      for (int k = 0; k < 5; k++) begin
         t_halt(k);
      end
      t_stop(8'h00, 1'b0, 3);
      t_stop(8'h07, 1'b1, 16);
      t_wdt;
      close_out;
   end
endmodule
`default_nettype wire
